// file: csr_defines.svh
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// register offsets
`define CSR_GAIN_SEL_OFS 8'h90
`define CSR_STATUS_OFS 8'h93
`define CSR_Z_LOW_OFS 8'h94
`define CSR_Z_HIGH_OFS 8'h95
`define CSR_Y_LOW_OFS 8'h96
`define CSR_Y_HIGH_OFS 8'h97
`define CSR_IR1_LOW_OFS 8'h98
`define CSR_IR1_HIGH_OFS 8'h99
`define CSR_MUX_LOW_OFS 8'h9A
`define CSR_MUX_HIGH_OFS 8'h9B
`define CSR_GAIN_EXT_OFS 8'h9F
`define CSR_READ_CLR_OFS 8'hAB
`define CSR_INT_EN_OFS 8'hDD

// field positions
`define CSR_SAT_BIT 7
`define CSR_AINT_BIT 4
`define CSR_MUX_BIT 3
`define CSR_XGAIN_BIT 4
`define CSR_RDCLR_BIT 7
`define CSR_SAT_EN_BIT 7
`define CSR_AINT_EN_BIT 4

// reset values
`define CSR_GAIN_SEL_RST 8'h00
`define CSR_GAIN_EXT_RST 8'h04
`define CSR_READ_CLR_RST 8'h0C
`define CSR_INT_EN_RST 8'h00
`define CSR_RESULT_RST 16'h0000
`define CSR_DEV_ADDR_RST 7'h2A

// gain codes and multipliers
`define CSR_GAIN_64X_CODE 2'b11
`define CSR_FACTOR_1X 8'h01
`define CSR_FACTOR_4X 8'h04
`define CSR_FACTOR_16X 8'h10
`define CSR_FACTOR_64X 8'h40
`define CSR_FACTOR_128X 8'h80

`endif

// file: csr_pkg.sv
package csr_pkg;

  // one finished conversion from the analog front end
  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] ir_one;
    logic [15:0] x;
    logic [15:0] ir_two;
  } csr_conv_t;

  // gain setting handed to the analog front end
  typedef struct packed {
    logic [1:0] light_gain_code;
    logic extra_gain_active;
    logic [7:0] factor;
    logic fourth_channel_select;
  } csr_gain_t;

  typedef enum logic [2:0] {
    CSR_IDLE = 3'b000,
    CSR_ADDR = 3'b001,
    CSR_ADDR_ACK = 3'b010,
    CSR_WBYTE = 3'b011,
    CSR_WACK = 3'b100,
    CSR_RDATA = 3'b101,
    CSR_RACK = 3'b110
  } csr_state_t;

endpackage : csr_pkg

// file: csr_flag_cell.sv
`timescale 1ns/1ps
// sticky status flag: hardware set beats any clear in the same cycle
module csr_flag_cell (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic set,
  input wire logic w1c,
  input wire logic rd_clr,
  output logic flag
);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (w1c || rd_clr) begin
      flag <= 1'b0;
    end
  end

endmodule : csr_flag_cell

// file: csr_results.sv
`timescale 1ns/1ps
`include "csr_defines.svh"

// Functional notes
// - The saturation flag in status bit 7 is set by front-end saturation and cleared by writing a one to it.
// - The light interrupt flag in status bit 4 is set by interrupt events and is cleared by writing a one to it.
// - The Z result low byte reads at 0x94, read-only, reset to zero.
// - The Z result high byte reads at 0x95 and completes the 16-bit count.
// - The Y result reads as low byte at 0x96 and high byte at 0x97, read-only.
// - The first infrared result reads as low byte at 0x98 and high byte at 0x99, read-only.
// - The fourth result at 0x9A/0x9B carries X when the select bit is 0 and second infrared when it is 1.
// - The 128x gain is active only when the extra-gain bit 4 is set and the gain code is 11.
// - The two-bit gain code picks 1x, 4x, 16x or 64x.
// - With clear-on-read set, reading the status byte clears every flag.
// - The active-low interrupt pin is driven while the light interrupt flag or the saturation flag is set together with its own enable.
module csr_results import csr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `CSR_DEV_ADDR_RST  // arbitrary bus address
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_out,
  output logic int_oe,
  input wire logic conv_valid,
  input wire csr_conv_t conv_data,
  input wire logic sat_evt,
  input wire logic als_int_evt,
  output csr_gain_t gain
);

  // refuse an address from the reserved ranges at elaboration
  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
    $error("bus address falls in a reserved range");
  end

  logic [1:0] sync1, sync2;
  logic scl_d, sda_d;
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
  csr_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, txsh, ptr;
  logic rw, has_ptr, acked, busy;
  logic [7:0] gain_sel, gain_ext, read_clr, int_en;
  logic sat_flag, aint_flag;
  logic [3:0][15:0] res;
  logic [3:0][15:0] pend_data;
  logic pend;
  logic wr_en, rd_load, status_rd_clr, apply;
  logic [7:0] rd_byte;
  logic [3:0][15:0] src;

  // two-stage synchronisers on the bus pins
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
        end else begin
          sync1[gi] <= (gi == 0) ? scl_in : sda_in;
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // delayed copies for edge and start/stop detection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= sync2[0];
      sda_d <= sync2[1];
    end
  end

  assign scl_s = sync2[0];
  assign sda_s = sync2[1];
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_c = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c = scl_s && scl_d && !sda_d && sda_s;

  // register write and read strobes
  assign wr_en = scl_fall && state == CSR_WBYTE && bit_cnt == 4'h8 && has_ptr;
  assign rd_load = scl_fall && ((state == CSR_ADDR_ACK && rw) || (state == CSR_RACK && acked));
  assign status_rd_clr = rd_load && ptr == `CSR_STATUS_OFS && read_clr[`CSR_RDCLR_BIT];

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (ptr)
      `CSR_GAIN_SEL_OFS: rd_byte = gain_sel;
      `CSR_STATUS_OFS: rd_byte = {sat_flag, 2'b00, aint_flag, 4'h0};
      `CSR_Z_LOW_OFS: rd_byte = res[0][7:0];
      `CSR_Z_HIGH_OFS: rd_byte = res[0][15:8];
      `CSR_Y_LOW_OFS: rd_byte = res[1][7:0];
      `CSR_Y_HIGH_OFS: rd_byte = res[1][15:8];
      `CSR_IR1_LOW_OFS: rd_byte = res[2][7:0];
      `CSR_IR1_HIGH_OFS: rd_byte = res[2][15:8];
      `CSR_MUX_LOW_OFS: rd_byte = res[3][7:0];
      `CSR_MUX_HIGH_OFS: rd_byte = res[3][15:8];
      `CSR_GAIN_EXT_OFS: rd_byte = gain_ext;
      `CSR_READ_CLR_OFS: rd_byte = read_clr;
      `CSR_INT_EN_OFS: rd_byte = int_en;
      default: rd_byte = 8'h00;
    endcase
  end

  // bus protocol engine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= CSR_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      has_ptr <= 1'b0;
      acked <= 1'b0;
      busy <= 1'b0;
    end else if (start_c) begin
      state <= CSR_ADDR;
      bit_cnt <= 4'h0;
      has_ptr <= 1'b0;
      busy <= 1'b1;
    end else if (stop_c) begin
      state <= CSR_IDLE;
      busy <= 1'b0;
    end else if (scl_rise && state != CSR_IDLE) begin
      shreg <= {shreg[6:0], sda_s};
      bit_cnt <= bit_cnt + 4'h1;
      if (state == CSR_RACK) begin
        acked <= !sda_s;
      end
    end else if (scl_fall) begin
      case (state)
        CSR_ADDR: begin
          if (bit_cnt == 4'h8) begin
            // foreign address: sit idle until the next start
            state <= (shreg[7:1] == DEV_ADDR) ? CSR_ADDR_ACK : CSR_IDLE;
            rw <= shreg[0];
          end
        end
        CSR_ADDR_ACK: begin
          state <= rw ? CSR_RDATA : CSR_WBYTE;
          bit_cnt <= 4'h0;
        end
        CSR_WBYTE: begin
          if (bit_cnt == 4'h8) begin
            state <= CSR_WACK;
            has_ptr <= 1'b1;
          end
        end
        CSR_WACK: begin
          state <= CSR_WBYTE;
          bit_cnt <= 4'h0;
        end
        CSR_RDATA: begin
          if (bit_cnt == 4'h8) begin
            state <= CSR_RACK;
            bit_cnt <= 4'h0;
          end
        end
        CSR_RACK: begin
          state <= acked ? CSR_RDATA : CSR_IDLE;
          bit_cnt <= 4'h0;
        end
        default: state <= CSR_IDLE;
      endcase
    end
  end

  // register pointer: set by first written byte, advances after each data byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr <= 8'h00;
    end else if (scl_fall && state == CSR_WBYTE && bit_cnt == 4'h8) begin
      ptr <= has_ptr ? ptr + 8'h01 : shreg;
    end else if (scl_fall && state == CSR_RDATA && bit_cnt == 4'h8) begin
      ptr <= ptr + 8'h01;
    end
  end

  // data line: open drain, only ever pulled low, changed while clock is low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      txsh <= 8'hFF;
    end else if (start_c || stop_c) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (rd_load) begin
        txsh <= rd_byte;
        sda_oe <= !rd_byte[7];
      end else if (state == CSR_RDATA && bit_cnt != 4'h8) begin
        txsh <= {txsh[6:0], 1'b1};
        sda_oe <= !txsh[6];
      end else if ((state == CSR_ADDR && bit_cnt == 4'h8 && shreg[7:1] == DEV_ADDR) ||
                   (state == CSR_WBYTE && bit_cnt == 4'h8)) begin
        sda_oe <= 1'b1;
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  // configuration registers; reserved bits kept as written by software
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gain_sel <= `CSR_GAIN_SEL_RST;
      gain_ext <= `CSR_GAIN_EXT_RST;
      read_clr <= `CSR_READ_CLR_RST;
      int_en <= `CSR_INT_EN_RST;
    end else if (wr_en) begin
      case (ptr)
        `CSR_GAIN_SEL_OFS: gain_sel <= shreg;
        `CSR_GAIN_EXT_OFS: gain_ext <= shreg;
        `CSR_READ_CLR_OFS: read_clr <= shreg;
        `CSR_INT_EN_OFS: int_en <= shreg;
        default: ;
      endcase
    end
  end

  // status flags
  csr_flag_cell u_sat_flag (
    .clk(clk),
    .rst_b(rst_b),
    .set(sat_evt),
    .w1c(wr_en && ptr == `CSR_STATUS_OFS && shreg[`CSR_SAT_BIT]),
    .rd_clr(status_rd_clr),
    .flag(sat_flag)
  );

  csr_flag_cell u_aint_flag (
    .clk(clk),
    .rst_b(rst_b),
    .set(als_int_evt),
    .w1c(wr_en && ptr == `CSR_STATUS_OFS && shreg[`CSR_AINT_BIT]),
    .rd_clr(status_rd_clr),
    .flag(aint_flag)
  );

  // fourth channel source chosen when the conversion is captured
  always_comb begin
    src[0] = conv_data.z;
    src[1] = conv_data.y;
    src[2] = conv_data.ir_one;
    src[3] = gain_sel[`CSR_MUX_BIT] ? conv_data.ir_two : conv_data.x;
  end

  // results frozen during a transfer so split reads never tear
  assign apply = (conv_valid || pend) && !busy;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      res <= {4{`CSR_RESULT_RST}};
      pend_data <= {4{`CSR_RESULT_RST}};
      pend <= 1'b0;
    end else begin
      if (conv_valid) begin
        pend_data <= src;
      end
      if (apply) begin
        res <= conv_valid ? src : pend_data;
        pend <= 1'b0;
      end else if (conv_valid) begin
        pend <= 1'b1;
      end
    end
  end

  // interrupt pin and gain outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_out <= 1'b0;
      int_oe <= 1'b0;
      gain <= '0;
    end else begin
      int_oe <= (aint_flag && int_en[`CSR_AINT_EN_BIT]) ||
                (sat_flag && int_en[`CSR_SAT_EN_BIT]);
      gain.light_gain_code <= gain_sel[1:0];
      gain.fourth_channel_select <= gain_sel[`CSR_MUX_BIT];
      gain.extra_gain_active <= gain_ext[`CSR_XGAIN_BIT] && gain_sel[1:0] == `CSR_GAIN_64X_CODE;
      case (gain_sel[1:0])
        2'b00: gain.factor <= `CSR_FACTOR_1X;
        2'b01: gain.factor <= `CSR_FACTOR_4X;
        2'b10: gain.factor <= `CSR_FACTOR_16X;
        default: gain.factor <= gain_ext[`CSR_XGAIN_BIT] ? `CSR_FACTOR_128X : `CSR_FACTOR_64X;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence status_w1c_s(int b);
    wr_en && ptr == `CSR_STATUS_OFS && shreg[b];
  endsequence

  sequence status_cor_read_s;
    rd_load && ptr == `CSR_STATUS_OFS && read_clr[`CSR_RDCLR_BIT];
  endsequence

  sat_set_a: assert property (sat_evt |=> sat_flag && (ptr != `CSR_STATUS_OFS || rd_byte[`CSR_SAT_BIT]))
    else $error("saturation flag not set");
  sat_clear_a: assert property (status_w1c_s(`CSR_SAT_BIT) and !sat_evt |=> !sat_flag)
    else $error("saturation flag not cleared");
  aint_flag_a: assert property (als_int_evt |=> aint_flag)
    else $error("light interrupt flag not set");
  aint_clear_a: assert property (status_w1c_s(`CSR_AINT_BIT) and !als_int_evt |=> !aint_flag)
    else $error("light interrupt flag not cleared");
  z_bytes_a: assert property (rd_load && ptr == `CSR_Z_HIGH_OFS |=> txsh == $past(res[0][15:8]))
    else $error("z high byte wrong");
  mux_source_a: assert property (conv_valid && !busy |=> res[3] == ($past(gain_sel[`CSR_MUX_BIT]) ?
      $past(conv_data.ir_two) : $past(conv_data.x)))
    else $error("fourth channel source wrong");
  extra_gain_a: assert property (gain.extra_gain_active |-> gain.factor == `CSR_FACTOR_128X &&
      gain.light_gain_code == `CSR_GAIN_64X_CODE)
    else $error("extra gain outside 64x code");
  gain_factor_a: assert property ($stable(gain_sel) && gain_sel[1:0] == 2'b01 |=> gain.factor == `CSR_FACTOR_4X)
    else $error("gain factor wrong");
  read_clear_a: assert property (status_cor_read_s and !sat_evt and !als_int_evt |=> !sat_flag && !aint_flag)
    else $error("status not cleared on read");
  int_pin_a: assert property (aint_flag && int_en[`CSR_AINT_EN_BIT] |=> int_oe && !int_out)
    else $error("interrupt pin not driven");
  result_hold_a: assert property (busy && !stop_c |=> $stable(res))
    else $error("results changed during transfer");

endmodule : csr_results

// file: csr_host_model.sv
`timescale 1ns/1ps
// bus host: push-pull clock, open-drain data on a pulled-up wire
module csr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary bus address
) (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_oe
);
  logic [7:0] rd_buf [0:7];

  // bus idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // all pin moves land 1 ns after an edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // low and high phases of 10 cycles, margin over the 8 the device needs
  task automatic put_bit(input logic b);
    wt(4);
    sda_oe = ~b;
    wt(6);
    scl = 1'b1;
    wt(10);
    scl = 1'b0;
  endtask : put_bit

  task automatic get_bit(output logic b);
    wt(4);
    sda_oe = 1'b0;
    wt(6);
    scl = 1'b1;
    wt(5);
    b = sda_wire;
    wt(5);
    scl = 1'b0;
  endtask : get_bit

  // serves as repeated start when the clock is low
  task automatic start;
    if (scl === 1'b0) begin
      wt(4);
      sda_oe = 1'b0;
      wt(6);
      scl = 1'b1;
    end
    wt(10);
    sda_oe = 1'b1;
    wt(10);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    wt(4);
    sda_oe = 1'b1;
    wt(6);
    scl = 1'b1;
    wt(10);
    sda_oe = 1'b0;
    wt(20);
  endtask : stop

  task automatic put_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(a);
  endtask : put_byte

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] v);
    start;
    put_byte({DEV_ADDR, 1'b0});
    put_byte(ptr);
    put_byte(v);
    stop;
  endtask : write_reg

  // pointer write, repeated start, burst read, last byte refused
  task automatic read_regs(input logic [7:0] ptr, input int n);
    logic b;
    start;
    put_byte({DEV_ADDR, 1'b0});
    put_byte(ptr);
    start;
    put_byte({DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        get_bit(b);
        rd_buf[k][i] = b;
      end
      put_bit(k == n - 1);
    end
    stop;
  endtask : read_regs
endmodule : csr_host_model

// file: color_sensor_status_and_results_tb.sv
`timescale 1ns/1ps
module color_sensor_status_and_results_tb import csr_pkg::*; ;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic conv_valid = 1'b0;
  csr_conv_t conv_data = '0;
  logic sat_evt = 1'b0;
  logic als_int_evt = 1'b0;
  logic scl, host_oe, sda_oe, sda_out, int_out, int_oe;
  wire logic sda_wire;
  csr_gain_t gain;
  csr_conv_t cur, prev;
  int errors = 0;
  int compares = 0;

  // pulled-up data wire, low while either side pulls
  assign sda_wire = ~(host_oe | sda_oe);
  always #2 clk = ~clk;

  csr_results #(.DEV_ADDR(7'h2A)) i_dut (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe), .conv_valid(conv_valid),
    .conv_data(conv_data), .sat_evt(sat_evt), .als_int_evt(als_int_evt), .gain(gain));
  csr_host_model #(.DEV_ADDR(7'h2A)) i_host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_oe(host_oe));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    i_host.read_regs(ptr, 1);
    chk({8'h00, i_host.rd_buf[0]}, {8'h00, exp});
  endtask : rd

  // one-cycle conversion of random counts
  task automatic convert;
    logic [95:0] r;
    r = {$urandom(), $urandom(), $urandom()};
    cur = r[79:0];
    conv_data = cur;
    conv_valid = 1'b1;
    cycles(1);
    conv_valid = 1'b0;
  endtask : convert

  // both flag events together; flag then pin need two edges
  task automatic events;
    sat_evt = 1'b1;
    als_int_evt = 1'b1;
    cycles(1);
    sat_evt = 1'b0;
    als_int_evt = 1'b0;
    cycles(3);
  endtask : events

  function automatic logic [15:0] ch(input csr_conv_t c, input int k, input logic sel);
    case (k)
      0: return c.z;
      1: return c.y;
      2: return c.ir_one;
      default: return sel ? c.ir_two : c.x;
    endcase
  endfunction : ch

  function automatic logic [7:0] factor(input int m);
    case (m[1:0])
      2'b00: return 8'h01;
      2'b01: return 8'h04;
      2'b10: return 8'h10;
      default: return m[2] ? 8'h80 : 8'h40;
    endcase
  endfunction : factor

  // one burst over all eight result bytes, low byte first
  task automatic check_results(input csr_conv_t c, input logic sel);
    i_host.read_regs(8'h94, 8);
    for (int k = 0; k < 4; k++) begin
      chk({i_host.rd_buf[2 * k + 1], i_host.rd_buf[2 * k]}, ch(c, k, sel));
    end
  endtask : check_results

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    end_sim;
  end

  initial begin
    void'($urandom(82332));
    cycles(6);
    rst_b = 1'b1;
    check_results('0, 1'b0);
    rd(8'h9F, 8'h04);
    rd(8'hA0, 8'h00);
    chk({8'h00, gain.factor}, 16'h0001);
    repeat (3) begin
      convert;
      check_results(cur, 1'b0);
    end
    // result bytes ignore writes
    i_host.write_reg(8'h94, ~cur.z[7:0]);
    rd(8'h94, cur.z[7:0]);
    // every gain code, extension bit off and on, reserved bits kept
    for (int m = 0; m < 8; m++) begin
      i_host.write_reg(8'h90, {4'h0, 1'b1, 1'b0, m[1:0]});
      i_host.write_reg(8'h9F, m[2] ? 8'h14 : 8'h04);
      cycles(2);
      chk({14'h0000, gain.light_gain_code}, {14'h0000, m[1:0]});
      chk({15'h0000, gain.extra_gain_active}, {15'h0000, m[2] && m[1:0] == 2'b11});
      chk({8'h00, gain.factor}, {8'h00, factor(m)});
    end
    chk({15'h0000, gain.fourth_channel_select}, 16'h0001);
    convert;
    check_results(cur, 1'b1);
    // flags, pin enable on the light flag only
    i_host.write_reg(8'hDD, 8'h10);
    events;
    chk({15'h0000, int_oe}, 16'h0001);
    rd(8'h93, 8'h90);
    i_host.write_reg(8'h93, 8'h80);
    rd(8'h93, 8'h10);
    chk({15'h0000, int_oe}, 16'h0001);
    i_host.write_reg(8'h93, 8'h10);
    rd(8'h93, 8'h00);
    chk({15'h0000, int_oe}, 16'h0000);
    // clear-on-read: first read shows flags, second sees them gone
    i_host.write_reg(8'hAB, 8'h8C);
    events;
    rd(8'h93, 8'h90);
    rd(8'h93, 8'h00);
    chk({15'h0000, int_oe}, 16'h0000);
    // saturation alone drives the pin; light flag masked by its enable
    i_host.write_reg(8'hDD, 8'h80);
    events;
    chk({15'h0000, int_oe}, 16'h0001);
    i_host.write_reg(8'h93, 8'h80);
    chk({15'h0000, int_oe}, 16'h0000);
    // conversion lands while the low byte shifts out
    prev = cur;
    fork
      i_host.read_regs(8'h94, 2);
      begin
        cycles(700);
        convert;
      end
    join
    chk({i_host.rd_buf[1], i_host.rd_buf[0]}, prev.z);
    check_results(cur, 1'b1);
    // open-drain output values never go high
    chk({14'h0000, sda_out, int_out}, 16'h0000);
    end_sim;
  end
endmodule : color_sensor_status_and_results_tb
